// ===== bench/alc_gain_sequencer_test.sv
// Self-checking bench for the gain sequencer core.
// Drives host frames, sample ticks and level flags; results matched from queues.
`timescale 1ns/1ps
`default_nettype none
module alc_gain_sequencer_test;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       sampleTick = 1'b0;
    logic       overLimit = 1'b0;
    logic       overBand = 1'b1;
    logic [1:0] zeroCross = 2'b00;
    logic [1:0] tickDiv = 2'b00;
    logic       rateSel = 1'b0;
    logic [1:0] limSel = 2'b00;
    logic [1:0] ztSel = 2'b00;
    logic [1:0] waitSel = 2'b00;
    logic [1:0] fadeSel = 2'b00;
    logic       ctlSelectN, ctlClk, ctlDataIn, ctlDataOut, ctlDataOutEn;
    logic       limitThresholdSelect, statusManual, rdDone;
    logic [6:0] inputGainCode, gainLeft, gainRight;
    logic [7:0] rdByte;
    logic [7:0] expByte[$];
    logic [6:0] expGain[$];
    int         fails = 0;
    int         checks = 0;
    int         cycles = 0;
    int         seed = 24;

    alcgs_core dut (.core_clk(core_clk), .rst(rst), .sampleTick(sampleTick),
        .overLimit(overLimit), .overBand(overBand), .zeroCross(zeroCross),
        .sampleRateSelect(rateSel), .limiterPeriodSelect(limSel), .zeroCrossTimeoutSelect(ztSel),
        .recoveryWaitSelect(waitSel), .fadePeriodSelect(fadeSel), .ctlSelectN(ctlSelectN),
        .ctlClk(ctlClk), .ctlDataIn(ctlDataIn), .ctlDataOut(ctlDataOut),
        .ctlDataOutEn(ctlDataOutEn), .limitThresholdSelect(limitThresholdSelect),
        .inputGainCode(inputGainCode), .gainLeft(gainLeft), .gainRight(gainRight),
        .statusManual(statusManual));
    alcgs_host_model host (.core_clk(core_clk), .ctlDataOut(ctlDataOut),
        .ctlSelectN(ctlSelectN), .ctlClk(ctlClk), .ctlDataIn(ctlDataIn),
        .rdDone(rdDone), .rdByte(rdByte));

    // Clock
    always #2.5 core_clk = ~core_clk;

    // Tick every fourth cycle, random zero crossings, hang limit
    always @(negedge core_clk) begin
        tickDiv <= tickDiv + 2'd1;
        sampleTick <= (tickDiv == 2'd3);
        zeroCross <= 2'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fails++;
            complete_run();
        end
    end

    task automatic report(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
        report(e, g);
    endtask
    task automatic cmp7(input logic [6:0] e, input logic [6:0] g);
        report({1'b0, e}, {1'b0, g});
    endtask
    task automatic cmp1(input logic e, input logic g);
        report({7'h00, e}, {7'h00, g});
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, 2 + ($random(seed) & 1));
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        expByte.push_back(e);
        host.xfer(1'b0, a, 8'h00, 2 + ($random(seed) & 1));
    endtask
    // Bounded wait for all gain notes to be used up
    task automatic drain(input int lim);
        for (int n = 0; n < lim && expGain.size() != 0; n++) @(negedge core_clk);
        cmp1(1'b1, expGain.size() == 0);
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Match read bytes and gain changes to the oldest notes
    always @(posedge rdDone) cmp8(expByte.size() ? expByte.pop_front() : 8'hxx, rdByte);
    always @(inputGainCode) if (!rst) cmp7(expGain.size() ? expGain.pop_front() : 7'hxx, inputGainCode);

    // Main sequence
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        wr(alcgs_pkg::ADDR_GAIN, 8'h05);
        cmp1(1'b0, statusManual);
        repeat (4128 * 4 + 40) @(negedge core_clk);
        cmp1(1'b1, statusManual);
        rd(alcgs_pkg::ADDR_MODE1, 8'h00);
        rd(alcgs_pkg::ADDR_REF, 8'h28);
        rd(alcgs_pkg::ADDR_OPMODE, 8'h08);
        rd(5'h08, 8'h00);
        wr(alcgs_pkg::ADDR_REF, 8'h09);
        expGain.push_back(7'h05);
        wr(alcgs_pkg::ADDR_GAIN, 8'h05);
        wr(alcgs_pkg::ADDR_MODE1, 8'h3b);
        rd(alcgs_pkg::ADDR_MODE1, 8'h3b);
        cmp1(1'b1, limitThresholdSelect);
        wr(alcgs_pkg::ADDR_OPMODE, 8'h31);
        rd(alcgs_pkg::ADDR_OPMODE, 8'h31);
        expGain.push_back(7'h01);
        expGain.push_back(7'h00);
        limSel = 2'b01;
        repeat (2) begin
            overLimit = 1'b1;
            repeat (4) @(negedge core_clk);
            overLimit = 1'b0;
            repeat (40) @(negedge core_clk);
        end
        drain(100);
        for (int g = 2; g <= 8; g += 2) expGain.push_back(7'(g));
        expGain.push_back(7'h09);
        waitSel = 2'b01;
        overBand = 1'b0;
        drain(11000);
        // Impulse-tolerant mode: one over-limit sample is ignored, two in a row attenuate
        overBand = 1'b1;
        ztSel = 2'b01;
        wr(alcgs_pkg::ADDR_OPMODE, 8'h21);
        overLimit = 1'b1;
        repeat (4) @(negedge core_clk);
        overLimit = 1'b0;
        repeat (20) @(negedge core_clk);
        expGain.push_back(7'h05);
        overLimit = 1'b1;
        repeat (8) @(negedge core_clk);
        overLimit = 1'b0;
        drain(100);
        wr(alcgs_pkg::ADDR_OPMODE, 8'h30);
        for (int n = 0; n < 3000 && statusManual !== 1'b1; n++) @(negedge core_clk);
        cmp1(1'b1, statusManual);
        expGain.push_back(7'h09);
        wr(alcgs_pkg::ADDR_GAIN, 8'h09);
        for (int g = 7; g >= 1; g -= 2) expGain.push_back(7'(g));
        expGain.push_back(7'h00);
        wr(alcgs_pkg::ADDR_OPMODE, 8'h32);
        drain(20000);
        repeat (3200) @(negedge core_clk);
        for (int g = 2; g <= 8; g += 2) expGain.push_back(7'(g));
        expGain.push_back(7'h09);
        rateSel = 1'b1;
        wr(alcgs_pkg::ADDR_OPMODE, 8'h34);
        drain(25000);
        repeat (3200) @(negedge core_clk);
        complete_run();
    end
endmodule
`default_nettype wire

// ===== bench/alcgs_host_model.sv
// Host processor model on the serial control port.
// Assumes core_clk is the device clock; frames go MSB first.
`timescale 1ns/1ps
`default_nettype none
module alcgs_host_model (
    input  wire logic core_clk,
    input  wire logic ctlDataOut,
    output logic      ctlSelectN,
    output logic      ctlClk,
    output logic      ctlDataIn,
    output logic      rdDone,
    output logic [7:0] rdByte
);
    initial begin
        ctlSelectN = 1'b1;
        ctlClk = 1'b0;
        ctlDataIn = 1'b0;
        rdDone = 1'b0;
        rdByte = 8'h00;
    end
    // One frame; read bits taken just before each rising serial clock
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, input int half);
        logic [15:0] frame;
        logic [7:0]  got;
        frame = {2'b00, wr, a, d};
        got = 8'h00;
        @(negedge core_clk);
        ctlSelectN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ctlClk = 1'b0;
            ctlDataIn = frame[i];
            repeat (half) @(negedge core_clk);
            if (i < 8) got[i] = ctlDataOut;
            ctlClk = 1'b1;
            repeat (half) @(negedge core_clk);
        end
        ctlClk = 1'b0;
        repeat (2) @(negedge core_clk);
        ctlSelectN = 1'b1;
        ctlDataIn = ~ctlDataIn; // Released line shows no stale level
        if (!wr) begin
            rdByte = got;
            rdDone = 1'b1;
            @(negedge core_clk);
            rdDone = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/alcgs_monitor.sv
// Port checker for the gain sequencer core.
// Bound to alcgs_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module alcgs_monitor (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       sampleTick,
    input wire logic       ctlSelectN,
    input wire logic       ctlDataOutEn,
    input wire logic       limitThresholdSelect,
    input wire logic [6:0] inputGainCode,
    input wire logic [6:0] gainLeft,
    input wire logic [6:0] gainRight,
    input wire logic       statusManual
);
    logic [12:0] initCnt_q;
    logic [12:0] initCnt_d;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Counts ticks of the initialising sequence
    always_comb begin
        initCnt_d = initCnt_q;
        if (sampleTick && initCnt_q < 13'd4128) begin
            initCnt_d = initCnt_q + 13'd1;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            initCnt_q <= 13'd0;
        end else begin
            initCnt_q <= initCnt_d;
        end
    end

    property p_resetValues;
        $fell(rst) |-> inputGainCode == 7'h28 && !statusManual && !limitThresholdSelect;
    endproperty
    a_resetValues: assert property (p_resetValues) else $error("bad values after reset");
    property p_initStatus;
        initCnt_q < 13'd4128 |-> !statusManual;
    endproperty
    a_initStatus: assert property (p_initStatus) else $error("status high during init");
    property p_autoStep;
        (!$past(statusManual) && inputGainCode != $past(inputGainCode))
            |-> 8'(8'(inputGainCode) - 8'($past(inputGainCode)) + 8'd4) <= 8'd8;
    endproperty
    a_autoStep: assert property (p_autoStep) else $error("automatic step above four");
    property p_autoOnTick;
        (!$past(statusManual) && inputGainCode != $past(inputGainCode)) |-> $past(sampleTick);
    endproperty
    a_autoOnTick: assert property (p_autoOnTick) else $error("gain moved off tick");
    property p_leftFollows;
        gainLeft != $past(gainLeft)
            |-> gainLeft == $past(inputGainCode) || gainLeft == $past(inputGainCode, 2);
    endproperty
    a_leftFollows: assert property (p_leftFollows) else $error("left gain not shared code");
    property p_rightFollows;
        gainRight != $past(gainRight)
            |-> gainRight == $past(inputGainCode) || gainRight == $past(inputGainCode, 2);
    endproperty
    a_rightFollows: assert property (p_rightFollows) else $error("right gain not shared code");
    property p_statusApplied;
        statusManual |-> gainLeft == inputGainCode && gainRight == inputGainCode;
    endproperty
    a_statusApplied: assert property (p_statusApplied) else $error("idle with step pending");
    property p_thresholdByHost;
        limitThresholdSelect != $past(limitThresholdSelect) |-> !$past(ctlSelectN);
    endproperty
    a_thresholdByHost: assert property (p_thresholdByHost) else $error("threshold moved");
    property p_readDriveSelected;
        ctlDataOutEn |-> !ctlSelectN && !$past(ctlSelectN, 8);
    endproperty
    a_readDriveSelected: assert property (p_readDriveSelected) else $error("read drive unselected");
endmodule
bind alcgs_core alcgs_monitor mon (.core_clk(core_clk), .rst(rst), .sampleTick(sampleTick),
    .ctlSelectN(ctlSelectN), .ctlDataOutEn(ctlDataOutEn),
    .limitThresholdSelect(limitThresholdSelect),
    .inputGainCode(inputGainCode), .gainLeft(gainLeft), .gainRight(gainRight),
    .statusManual(statusManual));
`default_nettype wire

// ===== src/alcgs_core.sv
// Level control and fade gain sequencer with its register file.
// Assumes sampleTick pulses once per sample, level flags and
// zero-cross pulses are valid on that tick, rst is the power-down pin.
`timescale 1ns/1ps
`default_nettype none

module alcgs_core (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       sampleTick,
    input  wire logic       overLimit,
    input  wire logic       overBand,
    input  wire logic [1:0] zeroCross,
    input  wire logic       sampleRateSelect,
    input  wire logic [1:0] limiterPeriodSelect,
    input  wire logic [1:0] zeroCrossTimeoutSelect,
    input  wire logic [1:0] recoveryWaitSelect,
    input  wire logic [1:0] fadePeriodSelect,
    input  wire logic       ctlSelectN,
    input  wire logic       ctlClk,
    input  wire logic       ctlDataIn,
    output logic            ctlDataOut,
    output logic            ctlDataOutEn,
    output logic            limitThresholdSelect,
    output logic [6:0]      inputGainCode,
    output logic [6:0]      gainLeft,
    output logic [6:0]      gainRight,
    output logic            statusManual
);
    localparam int CW = alcgs_pkg::CNT_W;

    // Converts a count of 62.5 us units to samples at the selected rate
    function automatic logic [CW-1:0] toSamples(input int units, input logic fs48);
        toSamples = fs48 ? CW'(units * alcgs_pkg::SPU_HI)
                         : CW'(units * alcgs_pkg::SPU_LO);
    endfunction

    // Adds a step and saturates at the reference
    function automatic logic [6:0] stepUp(input logic [6:0] code,
                                          input logic [2:0] n,
                                          input logic [6:0] ref_v);
        logic [7:0] sum;
        sum = {1'b0, code} + {5'h00, n};
        if (code >= ref_v) begin
            stepUp = code;
        end else if (sum > {1'b0, ref_v}) begin
            stepUp = ref_v;
        end else begin
            stepUp = sum[6:0];
        end
    endfunction

    // Subtracts a step and clips at mute
    function automatic logic [6:0] stepDown(input logic [6:0] code,
                                            input logic [2:0] n);
        if ({1'b0, code} < {5'h00, n}) begin
            stepDown = alcgs_pkg::GAIN_MUTE;
        end else begin
            stepDown = code - {4'h0, n};
        end
    endfunction

    logic       wrStrobe;
    logic [4:0] regAddr;
    logic [7:0] wrData;
    logic [7:0] rdData;

    alcgs_serial_port u_port (
        .core_clk     (core_clk),
        .rst          (rst),
        .ctlSelectN   (ctlSelectN),
        .ctlClk       (ctlClk),
        .ctlDataIn    (ctlDataIn),
        .ctlDataOut   (ctlDataOut),
        .ctlDataOutEn (ctlDataOutEn),
        .wrStrobe     (wrStrobe),
        .regAddr      (regAddr),
        .wrData       (wrData),
        .rdData       (rdData)
    );

    // Register state
    logic [7:0]    mode1_q, mode1_d;
    logic [6:0]    ref_q, ref_d;
    logic [5:0]    opMode_q, opMode_d;
    logic [6:0]    gain_q, gain_d;
    logic [CW-1:0] initCnt_q, initCnt_d;
    logic          initBusy_q, initBusy_d;
    logic [CW-1:0] fadeCnt_q, fadeCnt_d;
    logic [CW-1:0] limCnt_q, limCnt_d;
    logic [CW-1:0] waitCnt_q, waitCnt_d;
    logic          overPrev_q, overPrev_d;
    logic          immed_q, immed_d;

    // Field decode
    logic       alcOn, fadeInOn, fadeOutOn, zcDisable, impulseMode;
    logic [2:0] recSteps, limSteps, fadeSteps;
    logic [CW-1:0] fadePeriod, limPeriod, waitPeriod, ztPeriod;
    logic       limitHit, limitFire, recoverFire, fadeFire;
    logic [1:0] chSettled;
    logic       allSettled;

    assign alcOn       = opMode_q[alcgs_pkg::OP_ALC];
    assign fadeOutOn   = opMode_q[alcgs_pkg::OP_FOUT];
    assign fadeInOn    = opMode_q[alcgs_pkg::OP_FIN];
    assign impulseMode = ~opMode_q[alcgs_pkg::OP_IMP];
    assign zcDisable   = opMode_q[alcgs_pkg::OP_ZCD];
    assign recSteps    = {1'b0, mode1_q[alcgs_pkg::MODE1_REC_LSB +: 2]} + 3'h1;
    assign limSteps    = {1'b0, mode1_q[alcgs_pkg::MODE1_LIM_LSB +: 2]} + 3'h1;
    assign fadeSteps   = mode1_q[alcgs_pkg::MODE1_FADE] ? 3'h2 : 3'h1;
    assign limitThresholdSelect = mode1_q[alcgs_pkg::MODE1_THR];

    // Period selection, all counted in samples
    assign fadePeriod = toSamples(alcgs_pkg::FADE_MS[fadePeriodSelect]
                                  * alcgs_pkg::UNITS_PER_MS, sampleRateSelect);
    assign ztPeriod   = toSamples(alcgs_pkg::WAIT_MS[zeroCrossTimeoutSelect]
                                  * alcgs_pkg::UNITS_PER_MS, sampleRateSelect);
    assign waitPeriod = toSamples(alcgs_pkg::WAIT_MS[recoveryWaitSelect]
                                  * alcgs_pkg::UNITS_PER_MS, sampleRateSelect);
    assign limPeriod  = zcDisable
                      ? toSamples(alcgs_pkg::LIM_UNITS[limiterPeriodSelect], sampleRateSelect)
                      : ztPeriod;

    // Step triggers for this sample
    assign limitHit    = overLimit & (~impulseMode | overPrev_q);
    assign limitFire   = sampleTick & alcOn & limitHit & (limCnt_q == '0);
    assign recoverFire = sampleTick & alcOn & ~overBand
                         & (waitCnt_q == waitPeriod - CW'(1));
    assign fadeFire    = sampleTick & (fadeInOn | fadeOutOn)
                         & (fadeCnt_q == fadePeriod - CW'(1));

    // Initialising sequence after power-down release
    always_comb begin
        initCnt_d  = initCnt_q;
        initBusy_d = initBusy_q;
        if (initBusy_q && sampleTick) begin
            if (initCnt_q == alcgs_pkg::INIT_SAMPLES - CW'(1)) begin
                initBusy_d = 1'b0;
            end else begin
                initCnt_d = initCnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            initCnt_q  <= '0;
            initBusy_q <= 1'b1;
        end else begin
            initCnt_q  <= initCnt_d;
            initBusy_q <= initBusy_d;
        end
    end

    // Timers for limiter holdoff, recovery wait and fade period
    always_comb begin
        limCnt_d   = limCnt_q;
        waitCnt_d  = waitCnt_q;
        fadeCnt_d  = fadeCnt_q;
        overPrev_d = overPrev_q;
        if (sampleTick) begin
            overPrev_d = overLimit;
            if (limitFire) begin
                limCnt_d = limPeriod - CW'(1);
            end else if (limCnt_q != '0) begin
                limCnt_d = limCnt_q - CW'(1);
            end
            if (!alcOn || overBand || recoverFire) begin
                waitCnt_d = '0;
            end else begin
                waitCnt_d = waitCnt_q + CW'(1);
            end
            if (!(fadeInOn || fadeOutOn) || fadeFire) begin
                fadeCnt_d = '0;
            end else begin
                fadeCnt_d = fadeCnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            limCnt_q   <= '0;
            waitCnt_q  <= '0;
            fadeCnt_q  <= '0;
            overPrev_q <= 1'b0;
        end else begin
            limCnt_q   <= limCnt_d;
            waitCnt_q  <= waitCnt_d;
            fadeCnt_q  <= fadeCnt_d;
            overPrev_q <= overPrev_d;
        end
    end

    // Register file and the shared gain code
    always_comb begin
        mode1_d  = mode1_q;
        ref_d    = ref_q;
        opMode_d = opMode_q;
        gain_d   = gain_q;
        immed_d  = immed_q & ~allSettled;
        if (limitFire) begin
            gain_d  = stepDown(gain_q, limSteps);
            immed_d = zcDisable;
        end else if (fadeFire) begin
            if (fadeOutOn) begin
                gain_d = stepDown(gain_q, fadeSteps);
            end else begin
                gain_d = stepUp(gain_q, fadeSteps, ref_q);
            end
        end else if (recoverFire) begin
            gain_d = stepUp(gain_q, recSteps, ref_q);
        end
        if (wrStrobe && !initBusy_q) begin
            case (regAddr)
                alcgs_pkg::ADDR_MODE1: begin
                    mode1_d = {2'b00, wrData[5:0]};
                end
                alcgs_pkg::ADDR_REF: begin
                    ref_d = wrData[6:0];
                end
                alcgs_pkg::ADDR_OPMODE: begin
                    opMode_d = {wrData[5:4], 1'b0, wrData[2:0]};
                end
                alcgs_pkg::ADDR_GAIN: begin
                    gain_d = wrData[6:0];
                end
                default: begin
                    mode1_d = mode1_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode1_q  <= alcgs_pkg::RST_MODE1;
            ref_q    <= alcgs_pkg::RST_REF;
            opMode_q <= alcgs_pkg::RST_OPMODE[5:0];
            gain_q   <= alcgs_pkg::RST_GAIN;
            immed_q  <= 1'b0;
        end else begin
            mode1_q  <= mode1_d;
            ref_q    <= ref_d;
            opMode_q <= opMode_d;
            gain_q   <= gain_d;
            immed_q  <= immed_d;
        end
    end

    // Per-channel application at zero cross or timeout, or at once after a limiter step with zcDisable set
    logic [6:0]    chGain_q [2];
    logic [6:0]    chGain_d [2];
    logic [CW-1:0] chCnt_q  [2];
    logic [CW-1:0] chCnt_d  [2];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            always_comb begin
                chGain_d[ch] = chGain_q[ch];
                chCnt_d[ch]  = chCnt_q[ch];
                if (chGain_q[ch] == gain_q) begin
                    chCnt_d[ch] = '0;
                end else if (immed_q) begin
                    chGain_d[ch] = gain_q;
                    chCnt_d[ch]  = '0;
                end else if (sampleTick) begin
                    if (zeroCross[ch] || chCnt_q[ch] == ztPeriod - CW'(1)) begin
                        chGain_d[ch] = gain_q;
                        chCnt_d[ch]  = '0;
                    end else begin
                        chCnt_d[ch] = chCnt_q[ch] + CW'(1);
                    end
                end
            end

            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    chGain_q[ch] <= alcgs_pkg::RST_GAIN;
                    chCnt_q[ch]  <= '0;
                end else begin
                    chGain_q[ch] <= chGain_d[ch];
                    chCnt_q[ch]  <= chCnt_d[ch];
                end
            end

            assign chSettled[ch] = (chGain_q[ch] == gain_q);
        end
    endgenerate

    assign allSettled = &chSettled;

    // Status: manual only when idle, initialised and no step pending
    assign statusManual = ~initBusy_q & ~alcOn & ~fadeInOn & ~fadeOutOn
                          & allSettled;

    // Read mux for the control port
    always_comb begin
        case (regAddr)
            alcgs_pkg::ADDR_MODE1:  rdData = mode1_q;
            alcgs_pkg::ADDR_REF:    rdData = {1'b0, ref_q};
            alcgs_pkg::ADDR_OPMODE: rdData = {2'b00, opMode_q[5:4], statusManual,
                                              opMode_q[2:0]};
            alcgs_pkg::ADDR_GAIN:   rdData = {1'b0, gain_q};
            default:                rdData = 8'h00;
        endcase
    end

    assign inputGainCode = gain_q;
    assign gainLeft      = chGain_q[0];
    assign gainRight     = chGain_q[1];
endmodule
`default_nettype wire

// ===== src/alcgs_pkg.sv
// Constants for the level control and fade gain sequencer.
// Assumes a sample-rate strobe from the converter timebase.
package alcgs_pkg;

    // Register addresses on the serial control port
    localparam logic [4:0] ADDR_MODE1  = 5'h04;
    localparam logic [4:0] ADDR_REF    = 5'h05;
    localparam logic [4:0] ADDR_OPMODE = 5'h06;
    localparam logic [4:0] ADDR_GAIN   = 5'h07;

    // Values after reset
    localparam logic [7:0] RST_MODE1  = 8'h00;
    localparam logic [6:0] RST_REF    = 7'h28;
    localparam logic [7:0] RST_OPMODE = 8'h00;
    localparam logic [6:0] RST_GAIN   = 7'h28;
    localparam logic [6:0] GAIN_MUTE  = 7'h00;

    // Field positions in level_control_mode_one
    localparam int MODE1_THR     = 0;
    localparam int MODE1_REC_LSB = 1;
    localparam int MODE1_FADE    = 3;
    localparam int MODE1_LIM_LSB = 4;

    // Field positions in operation_mode_status
    localparam int OP_ALC  = 0;
    localparam int OP_FOUT = 1;
    localparam int OP_FIN  = 2;
    localparam int OP_STAT = 3;
    localparam int OP_IMP  = 4;
    localparam int OP_ZCD  = 5;

    // Serial frame: 2 op bits, write flag, 5 address bits, 8 data bits
    localparam int FRAME_BITS  = 16;
    localparam int HEADER_BITS = 8;
    localparam int HDR_WRITE   = 5;

    // Periods in ms and limiter periods in units of 62.5 us
    localparam int FADE_MS [4] = '{24, 32, 48, 64};
    localparam int WAIT_MS [4] = '{8, 16, 64, 512};
    localparam int LIM_UNITS [4] = '{1, 2, 4, 8};
    localparam int UNIT_NS = 62500;
    localparam int UNITS_PER_MS = 1000000 / UNIT_NS;

    // Samples per 62.5 us unit at the two rates
    localparam int FS_LO_KHZ = 32;
    localparam int FS_HI_KHZ = 48;
    localparam int SPU_LO = FS_LO_KHZ * UNIT_NS / 1000000;
    localparam int SPU_HI = FS_HI_KHZ * UNIT_NS / 1000000;

    // Initialising sequence after power-down release, in samples
    localparam logic [14:0] INIT_SAMPLES = 15'd4128;
    localparam int CNT_W = 15;

endpackage

// ===== src/alcgs_serial_port.sv
// Serial control port slave: select, clock, data in, data out.
// Assumes pins synchronous to core_clk and a slow serial clock.
`timescale 1ns/1ps
`default_nettype none
module alcgs_serial_port (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ctlSelectN,
    input  wire logic       ctlClk,
    input  wire logic       ctlDataIn,
    output logic            ctlDataOut,
    output logic            ctlDataOutEn,
    output logic            wrStrobe,
    output logic [4:0]      regAddr,
    output logic [7:0]      wrData,
    input  wire logic [7:0] rdData
);
    logic       clkPrev_q, clkPrev_d;
    logic [4:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] hdr_q, hdr_d;
    logic [7:0] out_q, out_d;
    logic       wr_q, wr_d;
    logic [7:0] wdat_q, wdat_d;
    logic       rise, fall;

    assign rise = ctlClk & ~clkPrev_q;
    assign fall = ~ctlClk & clkPrev_q;

    // Shift in on rising edges, drive read data on falling edges
    always_comb begin
        clkPrev_d = ctlClk;
        cnt_d     = cnt_q;
        shift_d   = shift_q;
        hdr_d     = hdr_q;
        out_d     = out_q;
        wr_d      = 1'b0;
        wdat_d    = wdat_q;
        if (ctlSelectN) begin
            cnt_d = 5'h00;
        end else if (rise && cnt_q < 5'(alcgs_pkg::FRAME_BITS)) begin
            shift_d = {shift_q[6:0], ctlDataIn};
            cnt_d   = cnt_q + 5'h01;
            if (cnt_q == 5'(alcgs_pkg::HEADER_BITS - 1)) begin
                hdr_d = {shift_q[6:0], ctlDataIn};
            end
            if (cnt_q == 5'(alcgs_pkg::FRAME_BITS - 1) && hdr_q[alcgs_pkg::HDR_WRITE]) begin
                wr_d   = 1'b1;
                wdat_d = {shift_q[6:0], ctlDataIn};
            end
        end else if (fall) begin
            if (cnt_q == 5'(alcgs_pkg::HEADER_BITS)) begin
                out_d = rdData;
            end else begin
                out_d = {out_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clkPrev_q <= 1'b0;
            cnt_q     <= 5'h00;
            shift_q   <= 8'h00;
            hdr_q     <= 8'h00;
            out_q     <= 8'h00;
            wr_q      <= 1'b0;
            wdat_q    <= 8'h00;
        end else begin
            clkPrev_q <= clkPrev_d;
            cnt_q     <= cnt_d;
            shift_q   <= shift_d;
            hdr_q     <= hdr_d;
            out_q     <= out_d;
            wr_q      <= wr_d;
            wdat_q    <= wdat_d;
        end
    end

    // Read drive is enabled in a read frame from the rising edge of the first data bit until select is released
    assign ctlDataOut   = out_q[7];
    assign ctlDataOutEn = ~ctlSelectN & ~hdr_q[alcgs_pkg::HDR_WRITE]
                          & (cnt_q > 5'(alcgs_pkg::HEADER_BITS));
    assign wrStrobe     = wr_q;
    assign regAddr      = hdr_q[4:0];
    assign wrData       = wdat_q;
endmodule
`default_nettype wire
